// File: common/urs_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * receive status and RTS control block.
 * Assumes a 25 MHz block clock and a 4-bit register address.
 */
`ifndef URS_MAP_SVH
`define URS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define URS_A_DATA     4'h0
`define URS_A_LSR      4'h1
`define URS_A_RST      4'h2
`define URS_A_FLR      4'h3
`define URS_A_MSR      4'h4
`define URS_A_TRANSMIT_MACHINE_STATUS_REG     4'h5
`define URS_A_ICM      4'h6
`define URS_A_RCM      4'h7
`define URS_A_TMD      4'h8
`define URS_A_RXMODE   4'h9
`define URS_A_ADDRESS_COMPARE_ZERO     4'hA
`define URS_A_ADDRESS_COMPARE_ONE     4'hB
`define URS_A_IST      4'hC
`define URS_A_IMR      4'hD

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define URS_ICM_CLR    2
`define URS_RCM_LOCK   7
`define URS_RCM_FFIFO  5
`define URS_RCM_FMACH  4
`define URS_RCM_EN     3
`define URS_TMD_RTS    2
`define URS_RXM_AACK   2
`define URS_MODE_OFF   2'h0
`define URS_MODE_SEMI  2'h1
`define URS_MODE_FULL  2'h2
`define URS_RESET_8    8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define URS_CLK_HZ     25000000
`define URS_BAUD_HZ    115200
`define URS_BIT_CYC    (`URS_CLK_HZ / `URS_BAUD_HZ)

`endif

// File: common/urs_pkg.sv
/*
 * Types shared by the receive status and RTS control block.
 * Assumes urs_map.svh for widths of the register fields.
 */
package urs_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } urs_bus_t;

    typedef struct packed {
        logic [7:0] data;
        logic       abit;
        logic       ferr;
    } urs_rx_char_t;

    typedef enum logic [4:0] {
        URS_IDLE  = 5'h01,
        URS_LEAD  = 5'h02,
        URS_START = 5'h04,
        URS_DATA  = 5'h08,
        URS_STOP  = 5'h10
    } urs_tx_state_t;

endpackage

// File: hw/urs_fifo_mem.sv
/*
 * Eight-entry receive character store with a registered read port.
 * Assumes the caller keeps pointers and fill level.
 */
`timescale 1ns/1ps

module urs_fifo_mem
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [2:0] raddr,
    output logic      [7:0] rdata_q
);
    logic [7:0] mem [8];

    always_ff @(posedge clock)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 8'h00;
        else
            rdata_q <= mem[raddr];
    end
endmodule

// File: hw/urs_rx_deser.sv
/*
 * Receive deserialiser: start bit, eight data bits, address bit, stop bit.
 * Assumes rxd comes from a pin; it is synchronised here.
 */
`timescale 1ns/1ps
`include "urs_map.svh"

module urs_rx_deser
    import urs_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst_b,
    input  wire logic   rxd,
    input  wire logic   en,
    input  wire logic   flush,
    output urs_rx_char_t chr_q,
    output logic        vld_q
);
    logic       rxd_m_q;
    logic       rxd_s_q;
    logic       busy_q;
    logic [7:0] div_q;
    logic [3:0] bn_q;
    logic [8:0] sh_q;
    wire        tick = busy_q && div_q == 8'h00;
    wire        fall = en && !busy_q && !rxd_s_q;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_m_q <= 1'b1;
            rxd_s_q <= 1'b1;
        end
        else
        begin
            rxd_m_q <= rxd;
            rxd_s_q <= rxd_m_q;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy_q <= 1'b0;
            div_q  <= 8'h00;
            bn_q   <= 4'h0;
            sh_q   <= 9'h000;
            vld_q  <= 1'b0;
            chr_q  <= '0;
        end
        else
        begin
            vld_q <= 1'b0;
            if (flush)
            begin
                busy_q <= 1'b0;
            end
            else if (fall)
            begin
                // Sample mid-bit from here on.
                busy_q <= 1'b1;
                div_q  <= 8'(`URS_BIT_CYC / 2);
                bn_q   <= 4'h0;
            end
            else if (busy_q)
            begin
                div_q <= tick ? 8'(`URS_BIT_CYC - 1) : div_q - 8'h01;
                if (tick)
                begin
                    bn_q <= bn_q + 4'h1;
                    sh_q <= {rxd_s_q, sh_q[8:1]};
                    if (bn_q == 4'h0 && rxd_s_q)
                        busy_q <= 1'b0;
                    if (bn_q == 4'hA)
                    begin
                        busy_q <= 1'b0;
                        vld_q  <= 1'b1;
                        chr_q  <= '{data: sh_q[7:0], abit: sh_q[8],
                                    ferr: !rxd_s_q};
                    end
                end
            end
        end
    end
endmodule

// File: hw/urs_core.sv
/*
 * Receive status, interrupt acknowledge, receive command and RTS control.
 * Assumes a synchronous register port; rxd and cts_b are raw pins.
 */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "urs_map.svh"

module urs_core
    import urs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  urs_bus_t        bus,
    output logic      [7:0] rdata_q,
    input  wire logic       rxd,
    input  wire logic       cts_b,
    output logic            txd_q,
    output logic            rts_q,
    output logic            irq_q
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // A strobe here is already the chip-select qualified one.
    wire wr_lsr  = bus.wr && bus.addr == `URS_A_LSR;
    wire wr_data = bus.wr && bus.addr == `URS_A_DATA;
    wire wr_icm  = bus.wr && bus.addr == `URS_A_ICM;
    wire wr_rcm  = bus.wr && bus.addr == `URS_A_RCM;
    wire wr_tmd  = bus.wr && bus.addr == `URS_A_TMD;
    wire wr_rxm  = bus.wr && bus.addr == `URS_A_RXMODE;
    wire wr_address_compare_zero = bus.wr && bus.addr == `URS_A_ADDRESS_COMPARE_ZERO;
    wire wr_address_compare_one = bus.wr && bus.addr == `URS_A_ADDRESS_COMPARE_ONE;
    wire wr_ist  = bus.wr && bus.addr == `URS_A_IST;
    wire wr_imr  = bus.wr && bus.addr == `URS_A_IMR;
    wire rd_data = bus.rd && bus.addr == `URS_A_DATA;
    wire rd_rst  = bus.rd && bus.addr == `URS_A_RST;
    wire [7:0] wd = bus.wdata;

    // Several commands may share one write.
    wire st_clr = wr_icm && wd[`URS_ICM_CLR];
    wire c_en   = wr_rcm && wd[`URS_RCM_EN];
    wire c_fm   = wr_rcm && wd[`URS_RCM_FMACH];
    wire c_ff   = wr_rcm && wd[`URS_RCM_FFIFO];
    // Lock loses to a machine flush in the same write.
    wire c_lock = wr_rcm && wd[`URS_RCM_LOCK] && !c_fm;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [4:0] lsr_q, lsr_d;
    logic [2:0] wp_q, wp_d, rp_q, rp_d;
    logic [3:0] cnt_q, cnt_d;
    logic       lock_q, lock_d, open_q, open_d, en_q, en_d;
    logic [2:0] tmd_q, rxm_q;
    logic [7:0] address_compare_zero_q, address_compare_one_q, buf_q, sh_q;
    logic [3:0] ist_q, ist_d, imr_q;
    logic       transmit_machine_status_reg_q, msr_q, pend_q;
    logic       cts_m_q, cts_s_q, cts_p_q;
    urs_tx_state_t st_q, st_d;
    logic [7:0] div_q;
    logic [2:0] bn_q;
    urs_rx_char_t chr;
    logic       rx_vld;
    logic [7:0] mem_rd;

    urs_rx_deser u_rx
    (
        .clock (clock),
        .rst_b (rst_b),
        .rxd   (rxd),
        .en    (en_q),
        .flush (c_fm),
        .chr_q (chr),
        .vld_q (rx_vld)
    );

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    wire [1:0] mode  = rxm_q[1:0];
    wire       amode = mode != `URS_MODE_OFF;
    wire       rx_in = rx_vld && en_q;
    wire       match = chr.data == address_compare_zero_q || chr.data == address_compare_one_q;
    wire       adr   = rx_in && amode && chr.abit;
    wire       want  = rx_in && !chr.ferr && (!amode || (!chr.abit && open_q));
    // Nothing enters and nothing leaves while locked.
    wire       store = want && !lock_q && cnt_q != 4'h8;
    wire       ovr   = want && !lock_q && cnt_q == 4'h8;
    wire       pop   = rd_data && cnt_q != 4'h0 && !lock_q;
    wire       brk   = rx_in && chr.ferr && chr.data == 8'h00;
    wire       txdone;
    wire       cts_chg = cts_s_q != cts_p_q;
    wire [3:0] evt   = {cts_chg, txdone, ovr | (rx_in & chr.ferr), store};

    always_comb
    begin
        open_d = open_q;
        if (adr && mode == `URS_MODE_SEMI)
            open_d = 1'b1;
        else if (adr && mode == `URS_MODE_FULL)
            open_d = match;
        if (c_fm)
            open_d = 1'b0;
        lock_d = c_fm ? 1'b0 : (c_lock ? 1'b1 : lock_q);
        en_d   = en_q | c_en;
        wp_d   = store ? wp_q + 3'h1 : wp_q;
        rp_d   = pop ? rp_q + 3'h1 : rp_q;
        cnt_d  = cnt_q + {3'h0, store} - {3'h0, pop};
        lsr_d  = lsr_q;
        if (wr_lsr)
            lsr_d = wd[4:0];
        if (st_clr)
            lsr_d[4:1] = 4'h0;
        if (c_ff || (wr_lsr && !wd[0]))
        begin
            // Empty the level; data stays where it is.
            rp_d  = wp_d;
            cnt_d = {3'h0, store};
        end
        if (pop && cnt_d == 4'h0)
            lsr_d[0] = 1'b0;
        // Hardware sets win over any clear in the same cycle.
        lsr_d = lsr_d | {brk, rx_in & chr.ferr, adr, ovr, store};
    end

    urs_fifo_mem u_mem
    (
        .clock   (clock),
        .rst_b   (rst_b),
        .we      (store),
        .waddr   (wp_q),
        .wdata   (chr.data),
        .raddr   (rp_q),
        .rdata_q (mem_rd)
    );

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    wire aack = rxm_q[`URS_RXM_AACK] && pop;
    wire [3:0] ack_clr = aack ? 4'hF : ((rd_rst || rd_data) ? 4'h3 : 4'h0);

    always_comb
    begin
        ist_d = ist_q & ~ack_clr;
        if (wr_ist)
            ist_d = ist_d & ~wd[3:0];
        ist_d = ist_d | evt;
    end

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    wire manual = tmd_q[1:0] == 2'h0;
    wire tick   = div_q == 8'(`URS_BIT_CYC - 1);
    assign txdone = st_q == URS_STOP && tick;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            URS_IDLE:
                if (pend_q)
                    st_d = manual ? URS_START : URS_LEAD;
            URS_LEAD:
                if (tick)
                    st_d = URS_START;
            URS_START:
                if (tick)
                    st_d = URS_DATA;
            URS_DATA:
                if (tick && bn_q == 3'h7)
                    st_d = URS_STOP;
            URS_STOP:
                if (tick)
                    st_d = pend_q ? URS_START : URS_IDLE;
            default:
                st_d = URS_IDLE;
        endcase
    end

    wire load = pend_q && (st_q == URS_IDLE || txdone);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb
    begin
        case (bus.addr)
            `URS_A_DATA:   rd_mux = mem_rd;
            `URS_A_LSR:    rd_mux = {3'h0, lsr_q};
            `URS_A_RST:    rd_mux = {lock_q, open_q, 1'b0, lsr_q};
            `URS_A_FLR:    rd_mux = {4'h0, cnt_q};
            `URS_A_MSR:    rd_mux = {3'h0, !cts_s_q, 3'h0, msr_q};
            `URS_A_TRANSMIT_MACHINE_STATUS_REG:   rd_mux = {7'h00, transmit_machine_status_reg_q};
            `URS_A_TMD:    rd_mux = {5'h00, tmd_q};
            `URS_A_RXMODE: rd_mux = {4'h0, en_q, rxm_q};
            `URS_A_ADDRESS_COMPARE_ZERO:   rd_mux = address_compare_zero_q;
            `URS_A_ADDRESS_COMPARE_ONE:   rd_mux = address_compare_one_q;
            `URS_A_IST:    rd_mux = {4'h0, ist_q};
            `URS_A_IMR:    rd_mux = {4'h0, imr_q};
            default:       rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {lsr_q, wp_q, rp_q, cnt_q} <= '0;
            {lock_q, open_q, en_q, ist_q, imr_q} <= '0;
            {tmd_q, rxm_q, address_compare_zero_q, address_compare_one_q} <= '0;
            {transmit_machine_status_reg_q, msr_q, rdata_q, irq_q} <= '0;
            {cts_m_q, cts_s_q, cts_p_q} <= 3'h7;
        end
        else
        begin
            {lsr_q, wp_q, rp_q, cnt_q} <= {lsr_d, wp_d, rp_d, cnt_d};
            {lock_q, open_q, en_q, ist_q} <= {lock_d, open_d, en_d, ist_d};
            rdata_q <= bus.rd ? rd_mux : `URS_RESET_8;
            irq_q   <= |(ist_d & imr_q);
            {cts_m_q, cts_s_q, cts_p_q} <= {cts_b, cts_m_q, cts_s_q};
            transmit_machine_status_reg_q  <= txdone | (transmit_machine_status_reg_q & !st_clr);
            msr_q   <= cts_chg | (msr_q & !st_clr);
            if (wr_imr)  imr_q  <= wd[3:0];
            if (wr_tmd)  tmd_q  <= wd[2:0];
            if (wr_rxm)  rxm_q  <= wd[2:0];
            if (wr_address_compare_zero) address_compare_zero_q <= wd;
            if (wr_address_compare_one) address_compare_one_q <= wd;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q   <= URS_IDLE;
            {div_q, bn_q, sh_q, buf_q, pend_q} <= '0;
            {txd_q, rts_q} <= 2'h3;
        end
        else
        begin
            st_q  <= st_d;
            div_q <= (st_q == URS_IDLE || tick) ? 8'h00 : div_q + 8'h01;
            bn_q  <= (st_q == URS_DATA && tick) ? bn_q + 3'h1 : bn_q;
            if (load)
                sh_q <= buf_q;
            else if (st_q == URS_DATA && tick)
                sh_q <= {1'b1, sh_q[7:1]};
            // A second write while one waits is dropped.
            pend_q <= (pend_q && !load) || (wr_data && !pend_q);
            if (wr_data && !pend_q)
                buf_q <= wd;
            txd_q <= st_d == URS_START ? 1'b0
                   : (st_d == URS_DATA
                      ? ((st_q == URS_DATA && tick) ? sh_q[1] : sh_q[0])
                   : 1'b1);
            // Active high here; pin polarity is left to the pad.
            rts_q <= manual ? tmd_q[`URS_TMD_RTS]
                            : st_d != URS_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    lsr_write_a: assert property (
        wr_lsr && !rx_vld |=> lsr_q[4:1] == $past(wd[4:1]))
        else $error("line status write not loaded");
    flr_clear_a: assert property (
        wr_lsr && !wd[0] && !store |=> cnt_q == 4'h0)
        else $error("fill level not cleared");
    ptr_keep_a: assert property (
        wr_lsr && wd[0] && !store && !pop && !c_ff |=> $stable(wp_q)
        && $stable(rp_q))
        else $error("pointers moved by flag clear");
    icm_clear_a: assert property (
        st_clr && !rx_vld && !txdone && !cts_chg |=> lsr_q[4:1] == 4'h0
        && !transmit_machine_status_reg_q && !msr_q && lsr_q[0] == $past(lsr_q[0]))
        else $error("status clear incomplete");
    semi_open_a: assert property (
        adr && mode == `URS_MODE_SEMI && !c_fm |=> open_q)
        else $error("semi mode did not open");
    full_open_a: assert property (
        adr && mode == `URS_MODE_FULL |=> open_q == $past(match && !c_fm))
        else $error("full mode open mismatch");
    flush_unlock_a: assert property (
        c_fm |=> !lock_q ##1 lock_q == $past(c_lock))
        else $error("lock won over machine flush");
    rts_lead_a: assert property (
        st_q == URS_IDLE && st_d == URS_LEAD |=> rts_q && txd_q
        ##(`URS_BIT_CYC) rts_q && !txd_q)
        else $error("RTS lead time wrong");
    lock_hold_a: assert property (
        lock_q && !wr_rcm && !wr_lsr |=> $stable(wp_q) && $stable(rp_q))
        else $error("locked FIFO pointers moved");
    ack_a: assert property (
        (rd_rst || rd_data) && !store |=> !ist_q[0])
        else $error("read did not acknowledge");
    auto_ack_a: assert property (
        aack && evt == 4'h0 && !wr_imr |=> !irq_q)
        else $error("auto-ack left interrupt high");

    lead_c: cover property (st_q == URS_LEAD ##1 st_q == URS_START);
    addr_c: cover property (adr && match ##1 open_q);
    irq_c:  cover property ($rose(irq_q) ##[1:50] $fell(irq_q));
endmodule

// File: test/urs_station.sv
/*
 * Remote serial station: sends frames on rxd and holds the cts_b level.
 * Assumes the block samples rxd at the bit rate given in urs_map.svh.
 */
`timescale 1ns/1ps
`include "urs_map.svh"

module urs_station
(
    input  wire logic clock,
    output logic      rxd,
    output logic      cts_b
);
    initial
    begin
        rxd   = 1'b1;
        cts_b = 1'b1;
    end

    // Start, eight data bits low first, address bit, stop; the line then
    // idles high long enough for the receiver to store the character.
    task automatic send(input logic [7:0] d, input logic a);
        logic [8:0] f;
        f = {a, d};
        @(posedge clock);
        rxd <= 1'b0;
        repeat (`URS_BIT_CYC) @(posedge clock);
        for (int i = 0; i < 9; i++)
        begin
            rxd <= f[i];
            repeat (`URS_BIT_CYC) @(posedge clock);
        end
        rxd <= 1'b1;
        repeat (`URS_BIT_CYC + 4) @(posedge clock);
    endtask
endmodule

// File: test/tb_urs_core.sv
/*
 * Bench for urs_core: register tasks, station frames, RTS timing.
 * Assumes one 25 MHz clock and the register offsets of urs_map.svh.
 */
`timescale 1ns/1ps
`include "urs_map.svh"

module tb_urs_core
    import urs_pkg::*;
;
    localparam logic [3:0] a_line  = 4'h1;
    localparam logic [3:0] a_level = 4'h3;
    localparam logic [3:0] a_modem = 4'h4;
    localparam logic [3:0] a_txst  = 4'h5;
    localparam logic [3:0] a_cmd   = 4'h6;
    localparam logic [3:0] a_rxcmd = 4'h7;
    localparam logic [3:0] a_txmd  = 4'h8;

    logic       clock;
    logic       rst_b;
    urs_bus_t   bus;
    logic [7:0] rdata_q;
    logic       rxd;
    logic       cts_b;
    logic       txd_q;
    logic       rts_q;
    logic       irq_q;
    int         n_fail;
    int         checked;
    int         cnt;
    logic [7:0] got;

    urs_core dut
    (
        .clock   (clock),
        .rst_b   (rst_b),
        .bus     (bus),
        .rdata_q (rdata_q),
        .rxd     (rxd),
        .cts_b   (cts_b),
        .txd_q   (txd_q),
        .rts_q   (rts_q),
        .irq_q   (irq_q)
    );

    urs_station stn
    (
        .clock (clock),
        .rxd   (rxd),
        .cts_b (cts_b)
    );

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask

    // Every strobe is followed by an idle edge, so no signal is driven
    // twice in one time step when calls follow each other.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        @(negedge clock);
        got = rdata_q;
    endtask

    task automatic rdc(input string nm, input logic [3:0] a,
                       input logic [7:0] e);
        rd(a);
        chk(nm, e, got);
    endtask

    // Waits for irq (0), rts (1) or txd (2); cnt holds the cycles taken.
    task automatic wait_for(input int s, input logic v, input int lim);
        cnt = 0;
        #1;
        while ((s == 0 ? irq_q : s == 1 ? rts_q : txd_q) !== v)
        begin
            @(posedge clock);
            #1;
            cnt++;
            if (cnt > lim)
            begin
                n_fail++;
                $display("wrong value wait%0d exp %b got %b", s, v, ~v);
                give_verdict();
            end
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        n_fail  = 0;
        checked = 0;
        rst_b   = 1'b0;
        bus     = '0;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        rdc("line", a_line, 8'h00);
        rdc("level", a_level, 8'h00);
        wr(4'hE, 8'hFF);
        rdc("unmapped", 4'hE, 8'h00);
        wr(`URS_A_IMR, 8'h01);
        wr(a_rxcmd, 8'h08);
        stn.send(8'hA5, 1'b0);
        stn.send(8'h3C, 1'b0);
        rdc("level", a_level, 8'h02);
        chk("irq", 8'h01, {7'h0, irq_q});
        rdc("data", `URS_A_DATA, 8'hA5);
        wait_for(0, 1'b0, 2);
        wr(a_line, 8'h1E);
        rdc("line", a_line, 8'h1E);
        rdc("level", a_level, 8'h00);
        wr(a_line, 8'h10);
        rdc("rx status", `URS_A_RST, 8'h10);
        stn.send(8'h66, 1'b0);
        rdc("level", a_level, 8'h01);
        rdc("data", `URS_A_DATA, 8'h66);
        for (int m = 1; m < 3; m++)
        begin
            wr(a_txmd, 8'(m));
            wr(`URS_A_DATA, 8'h5A);
            wait_for(1, 1'b1, 10);
            wait_for(2, 1'b0, 400);
            chk("lead", 8'(`URS_BIT_CYC), 8'(cnt));
            repeat (`URS_BIT_CYC / 2) @(posedge clock);
            for (int i = 0; i < 8; i++)
            begin
                repeat (`URS_BIT_CYC) @(posedge clock);
                #1;
                got[i] = txd_q;
            end
            chk("tx byte", 8'h5A, got);
            chk("rts", 8'h01, {7'h0, rts_q});
            wait_for(1, 1'b0, 3 * `URS_BIT_CYC);
            rdc("tx status", a_txst, 8'h01);
        end
        wr(`URS_A_IMR, 8'h00);
        wait_for(0, 1'b0, 3);
        wr(`URS_A_IMR, 8'h05);
        wait_for(0, 1'b1, 3);
        wr(`URS_A_RXMODE, 8'h04);
        stn.send(8'h5C, 1'b0);
        rdc("data", `URS_A_DATA, 8'h5C);
        wait_for(0, 1'b0, 2);
        stn.cts_b <= 1'b0;
        repeat (8) @(posedge clock);
        rd(a_modem);
        chk("modem", 8'h01, got & 8'h01);
        wr(a_line, 8'h1F);
        wr(a_cmd, 8'h04);
        rdc("line", a_line, 8'h01);
        rd(a_modem);
        chk("modem", 8'h00, got & 8'h01);
        rdc("tx status", a_txst, 8'h00);
        stn.send(8'h01, 1'b0);
        wr(a_rxcmd, 8'hB8);
        rd(`URS_A_RST);
        chk("lock", 8'h00, got & 8'h80);
        rd(`URS_A_RXMODE);
        chk("enable", 8'h08, got & 8'h08);
        rdc("level", a_level, 8'h00);
        wr(a_rxcmd, 8'h88);
        rd(`URS_A_RST);
        chk("lock", 8'h80, got & 8'h80);
        stn.send(8'h42, 1'b0);
        rdc("level", a_level, 8'h00);
        wr(a_rxcmd, 8'h18);
        rd(`URS_A_RST);
        chk("lock", 8'h00, got & 8'h80);
        stn.send(8'h43, 1'b0);
        rdc("data", `URS_A_DATA, 8'h43);
        wr(4'hA, 8'h11);
        wr(4'hB, 8'h22);
        wr(`URS_A_RXMODE, 8'h01);
        stn.send(8'h55, 1'b1);
        stn.send(8'h77, 1'b0);
        rdc("level", a_level, 8'h01);
        wr(a_rxcmd, 8'h38);
        wr(`URS_A_RXMODE, 8'h02);
        stn.send(8'h55, 1'b1);
        stn.send(8'h78, 1'b0);
        rdc("level", a_level, 8'h00);
        stn.send(8'h22, 1'b1);
        stn.send(8'h79, 1'b0);
        rdc("data", `URS_A_DATA, 8'h79);
        stn.send(8'h11, 1'b1);
        stn.send(8'h7A, 1'b0);
        rdc("data", `URS_A_DATA, 8'h7A);
        wr(a_txmd, 8'h04);
        repeat (2) @(posedge clock);
        chk("rts", 8'h01, {7'h0, rts_q});
        wr(a_txmd, 8'h00);
        wr(`URS_A_DATA, 8'hC3);
        wait_for(2, 1'b0, 10);
        chk("rts", 8'h00, {7'h0, rts_q});
        wait_for(0, 1'b1, 12 * `URS_BIT_CYC);
        wr(`URS_A_IST, 8'h04);
        wait_for(0, 1'b0, 3);
        give_verdict();
    end
endmodule
